/* File: rtl/pll_div_config.sv */
// second synthesizer loop dividers and first group a output driver control
// assumes vco_tick is one-cycle enable per vco edge, synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module pll_div_config
    import pll_div_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic reg_we,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic vco_tick,
    input wire logic [2:0] other_drivers_off,
    output logic fb_pulse,
    output logic group_a_clk,
    output logic first_output_true_leg,
    output logic first_output_complement_leg,
    output logic hstl_en,
    output logic true_leg_en,
    output logic comp_leg_en,
    output logic group_a_div_pd,
    output logic vco_div_running
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t st_r;
    state_t st_nxt;
    logic update;
    logic vco_pulse;
    logic first_off;
    logic [8:0] ch_half;
    logic [2:0] omode;
    logic [1:0] opol;

    assign update = reg_we && reg_addr == UPDATE_ADDR && reg_wdata[UPDATE_BIT];
    assign omode = st_r.act.out[OUT_MODE_LSB +: 3];
    assign opol = st_r.act.out[OUT_POL_LSB +: 2];
    assign vco_pulse = vco_tick && st_r.vmode == VD_RUN && st_r.vcnt == st_r.act.vco - 4'h1;
    // undefined mode codes count as off so the divider may sleep
    assign first_off = st_r.act.out[OUT_PD_BIT] ||
        !(omode == MODE_HSTL || omode == MODE_CMOS_BOTH ||
          omode == MODE_CMOS_TRUE || omode == MODE_CMOS_COMP);
    assign ch_half = ({1'b0, st_r.act.ch} + 9'h001) >> 1;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // staging writes, update copies what was staged before this cycle
        if (reg_we) begin
            case (reg_addr)
                FEEDBACK_DIVIDE_VALUE_ADDR: st_nxt.stg.fb = reg_wdata;
                VCO_DIVIDE_SELECT_ADDR: st_nxt.stg.vco = reg_wdata[3:0];
                GROUP_A_DIVIDE_VALUE_ADDR: st_nxt.stg.ch = reg_wdata;
                OUTPUT_ZERO_DRIVER_CONFIG_ADDR: st_nxt.stg.out = reg_wdata[5:0];
                default: st_nxt.stg = st_r.stg;
            endcase
        end
        if (update) begin
            st_nxt.act = st_r.stg;
        end
        case (st_nxt.act.vco)
            4'h0, 4'h1, 4'h2, 4'hC, 4'hD, 4'hE: st_nxt.vmode = VD_OFF;
            VCO_RESET_CODE: st_nxt.vmode = VD_RESET;
            default: st_nxt.vmode = VD_RUN;
        endcase
        // vco divider
        case (st_r.vmode)
            VD_RUN: begin
                if (vco_tick) begin
                    st_nxt.vcnt = vco_pulse ? 4'h0 : st_r.vcnt + 4'h1;
                end
            end
            VD_RESET: st_nxt.vcnt = 4'h0;
            VD_OFF: st_nxt.vcnt = 4'h0;
            default: st_nxt.vcnt = 4'h0;
        endcase
        // feedback divider, idle on invalid settings
        st_nxt.fb_pulse = 1'b0;
        if (st_r.act.fb < FB_MIN || st_r.vmode != VD_RUN) begin
            st_nxt.fcnt = 8'h00;
        end else if (vco_pulse) begin
            if (st_r.fcnt == st_r.act.fb - 8'h01) begin
                st_nxt.fcnt = 8'h00;
                st_nxt.fb_pulse = 1'b1;
            end else begin
                st_nxt.fcnt = st_r.fcnt + 8'h01;
            end
        end
        // channel divider
        st_nxt.ch_pd = first_off && (&other_drivers_off);
        if (st_r.ch_pd) begin
            st_nxt.ccnt = 8'h00;
            st_nxt.ch_clk = 1'b0;
        end else begin
            if (vco_pulse) begin
                st_nxt.ccnt = st_r.ccnt == st_r.act.ch ? 8'h00 : st_r.ccnt + 8'h01;
            end
            // divide by one passes the vco divider pulse straight on
            if (st_r.act.ch == 8'h00) begin
                st_nxt.ch_clk = vco_pulse;
            end else begin
                st_nxt.ch_clk = {1'b0, st_nxt.ccnt} < ch_half;
            end
        end
        // driver enables
        st_nxt.hstl_en = 1'b0;
        st_nxt.true_en = 1'b0;
        st_nxt.comp_en = 1'b0;
        if (!st_r.act.out[OUT_PD_BIT]) begin
            case (omode)
                MODE_HSTL: st_nxt.hstl_en = 1'b1;
                MODE_CMOS_BOTH: begin
                    st_nxt.true_en = 1'b1;
                    st_nxt.comp_en = 1'b1;
                end
                MODE_CMOS_TRUE: st_nxt.true_en = 1'b1;
                MODE_CMOS_COMP: st_nxt.comp_en = 1'b1;
                default: st_nxt.hstl_en = 1'b0;
            endcase
        end
        // legs, polarity only in cmos, hstl is always complementary
        if (st_nxt.hstl_en) begin
            st_nxt.true_leg = st_r.ch_clk;
            st_nxt.comp_leg = !st_r.ch_clk;
        end else begin
            st_nxt.true_leg = st_nxt.true_en && (st_r.ch_clk ^ opol[1]);
            st_nxt.comp_leg = st_nxt.comp_en && (st_r.ch_clk ^ !opol[0]);
        end
        // read back staged values, unused bits zero
        case (reg_addr)
            FEEDBACK_DIVIDE_VALUE_ADDR: st_nxt.rdata = st_r.stg.fb;
            VCO_DIVIDE_SELECT_ADDR: st_nxt.rdata = {4'h0, st_r.stg.vco};
            GROUP_A_DIVIDE_VALUE_ADDR: st_nxt.rdata = st_r.stg.ch;
            OUTPUT_ZERO_DRIVER_CONFIG_ADDR: st_nxt.rdata = {2'h0, st_r.stg.out};
            default: st_nxt.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{stg: '{fb: FB_RST, vco: VCO_RST, ch: CH_RST, out: OUT_RST},
                      act: '{fb: FB_RST, vco: VCO_RST, ch: CH_RST, out: OUT_RST},
                      vmode: VD_RESET, vcnt: 4'h0, fcnt: 8'h00, ccnt: 8'h00,
                      fb_pulse: 1'b0, ch_clk: 1'b0, true_leg: 1'b0, comp_leg: 1'b0,
                      hstl_en: 1'b0, true_en: 1'b0, comp_en: 1'b0, ch_pd: 1'b1,
                      rdata: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = st_r.rdata;
    assign fb_pulse = st_r.fb_pulse;
    assign group_a_clk = st_r.ch_clk;
    assign first_output_true_leg = st_r.true_leg;
    assign first_output_complement_leg = st_r.comp_leg;
    assign hstl_en = st_r.hstl_en;
    assign true_leg_en = st_r.true_en;
    assign comp_leg_en = st_r.comp_en;
    assign group_a_div_pd = st_r.ch_pd;
    // run bit of the one-hot mode register, so the pin stays a plain flop output
    assign vco_div_running = st_r.vmode[1];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_fb_cause: assert property (st_r.fb_pulse |-> $past(vco_pulse) &&
        $past(st_r.act.fb) >= FB_MIN && $past(st_r.fcnt) == $past(st_r.act.fb) - 8'h01)
        else $error("feedback pulse without full count");
    a_vco_period: assert property (vco_pulse |-> st_r.act.vco >= VCO_MIN &&
        st_r.act.vco <= VCO_MAX && st_r.vcnt == st_r.act.vco - 4'h1)
        else $error("vco divider pulse at wrong count");
    a_vco_disabled: assert property ((st_r.act.vco inside {4'h0, 4'h1, 4'h2, 4'hC, 4'hD,
        4'hE}) |-> st_r.vmode == VD_OFF && !vco_pulse)
        else $error("vco divider not disabled");
    a_vco_reset: assert property (st_r.act.vco == VCO_RESET_CODE |=> st_r.vcnt == 4'h0
        && st_r.fcnt == 8'h00) else $error("vco divider left reset state");
    a_update_commit: assert property (update |=> st_r.act == $past(st_r.stg))
        else $error("update did not commit staging");
    a_staged_hold: assert property (!update |=> $stable(st_r.act))
        else $error("active settings changed without update");
    a_ch_wrap: assert property (vco_pulse && !st_r.ch_pd &&
        st_r.ccnt == st_r.act.ch |=> st_r.ccnt == 8'h00)
        else $error("channel divider wrap wrong");
    a_ch_powerdown: assert property (first_off && (&other_drivers_off) |=> st_r.ch_pd
        ##1 !st_r.ch_clk) else $error("channel divider not powered down");
    a_mode_true_only: assert property (omode == MODE_CMOS_TRUE &&
        !st_r.act.out[OUT_PD_BIT] |=> st_r.true_en && !st_r.comp_en && !st_r.hstl_en)
        else $error("true-only mode decode wrong");
    a_pol_normal: assert property (st_r.true_en && st_r.comp_en && opol == 2'b01 &&
        $stable(st_r.act) |=> st_r.true_leg == $past(st_r.ch_clk) &&
        st_r.comp_leg == $past(st_r.ch_clk)) else $error("polarity 01 wrong");
    a_pol_true_inv: assert property (st_r.true_en && st_r.comp_en && opol == 2'b11 &&
        $stable(st_r.act) |=> st_r.true_leg != $past(st_r.ch_clk) &&
        st_r.comp_leg == $past(st_r.ch_clk)) else $error("polarity 11 wrong");
    a_driver_pd: assert property (st_r.act.out[OUT_PD_BIT] |=> !st_r.true_en &&
        !st_r.comp_en && !st_r.hstl_en && !st_r.true_leg) else $error("driver not off");
    a_fb_idle: assert property (st_r.act.fb < FB_MIN |=> !st_r.fb_pulse)
        else $error("feedback pulse below minimum setting");
    a_ch_pd_clear: assert property (!(first_off && (&other_drivers_off)) |=> !st_r.ch_pd)
        else $error("channel divider asleep with a driver on");
    // legs checked only while the active config stands still, a change moves them a cycle late
    a_hstl_legs: assert property (st_r.hstl_en && $stable(st_r.act) |=>
        st_r.true_leg == $past(st_r.ch_clk) && st_r.comp_leg != $past(st_r.ch_clk))
        else $error("hstl legs not complementary");

    // covers: update into run, feedback pulse, leaving reset state, sleep, hstl running
    c_update: cover property (update ##1 st_r.vmode == VD_RUN);
    c_fb_pulse: cover property (st_r.fb_pulse);
    c_reset_then_run: cover property (st_r.vmode == VD_RESET ##[1:20] st_r.vmode == VD_RUN);
    c_ch_pd: cover property ($rose(st_r.ch_pd));
    c_hstl: cover property (st_r.hstl_en && !st_r.ch_pd);
endmodule : pll_div_config
`default_nettype wire

/* File: rtl/pll_div_pkg.sv */
// constants, field layouts and state types for the second-loop divider block
// assumes an 8-bit register access port with 16-bit addresses behind the serial port
// What this block does
// - the feedback divider divides by its eight-bit value for 20 to 255 and stays idle below 20.
// - the vco divider divides by its four-bit value for settings 3 to 11.
// - the vco divider is disabled for settings 0, 1, 2, 12, 13 and 14.
// - a vco divider setting of 15 holds the vco divider in its reset state.
// - writing one to bit 0 of address 0x0005 issues the input/output update.
// - the group a channel divider divides by its eight-bit value plus one.
// - the channel divider powers down when all four of its output drivers are off.
// - the first output mode field selects off, hstl, both cmos legs, true leg only or complement only.
// - polarity 00 gives true normal and complement inverted, 01 gives both normal, cmos only.
// - polarity 11 inverts the true leg and leaves the complement leg normal.
// - bit 0 of the first output config keeps the driver on when clear and off when set.
package pll_div_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] UPDATE_ADDR = 16'h0005;
    localparam int UPDATE_BIT = 0;
    localparam logic [15:0] FEEDBACK_DIVIDE_VALUE_ADDR = 16'h0203;
    localparam logic [15:0] VCO_DIVIDE_SELECT_ADDR = 16'h0204;
    localparam logic [15:0] GROUP_A_DIVIDE_VALUE_ADDR = 16'h0205;
    localparam logic [15:0] OUTPUT_ZERO_DRIVER_CONFIG_ADDR = 16'h0206;
    // ------------------------------------------------------------
    // field positions and codes
    // ------------------------------------------------------------
    localparam int OUT_MODE_LSB = 3;
    localparam int OUT_POL_LSB = 1;
    localparam int OUT_PD_BIT = 0;
    localparam logic [7:0] FB_MIN = 8'h14;
    localparam logic [3:0] VCO_MIN = 4'h3;
    localparam logic [3:0] VCO_MAX = 4'hB;
    localparam logic [3:0] VCO_RESET_CODE = 4'hF;
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_HSTL = 3'h1;
    localparam logic [2:0] MODE_CMOS_BOTH = 3'h4;
    localparam logic [2:0] MODE_CMOS_TRUE = 3'h5;
    localparam logic [2:0] MODE_CMOS_COMP = 3'h6;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] FB_RST = 8'h14;
    localparam logic [3:0] VCO_RST = 4'hF;
    localparam logic [7:0] CH_RST = 8'h00;
    localparam logic [5:0] OUT_RST = 6'h01;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        VD_OFF = 3'b001,
        VD_RUN = 3'b010,
        VD_RESET = 3'b100
    } vco_div_mode_t;
    typedef struct packed {
        logic [7:0] fb;
        logic [3:0] vco;
        logic [7:0] ch;
        logic [5:0] out;
    } cfg_t;
    typedef struct packed {
        cfg_t stg;
        cfg_t act;
        vco_div_mode_t vmode;
        logic [3:0] vcnt;
        logic [7:0] fcnt;
        logic [7:0] ccnt;
        logic fb_pulse;
        logic ch_clk;
        logic true_leg;
        logic comp_leg;
        logic hstl_en;
        logic true_en;
        logic comp_en;
        logic ch_pd;
        logic [7:0] rdata;
    } state_t;
endpackage : pll_div_pkg

/* File: sim/test_pll_div_config.sv */
// self-checking bench for the second-loop divider and first group a output block
// assumes the design checks its own assertions; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module test_pll_div_config;
    import pll_div_pkg::*;
    // ------------------------------------------------------------
    // stimulus and design
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_we = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic vco_tick = 1'b0;
    logic [2:0] other_drivers_off = 3'h0;
    logic [7:0] reg_rdata;
    logic fb_pulse, group_a_clk, true_leg, comp_leg, hstl_en, true_leg_en, comp_leg_en;
    logic group_a_div_pd, vco_div_running;
    int n_errors = 0;
    int check_count = 0;
    // ordinary cases: address, written byte, byte read back
    localparam logic [31:0] ROWS [7] = '{32'h0203_37_37, 32'h0204_F5_05, 32'h0205_A5_A5,
        32'h0206_FF_3F, 32'h0207_55_00, 32'h0005_00_00, 32'h0202_12_00};
    // enables {hstl, true, comp} per mode code; undefined codes leave the driver off
    localparam logic [2:0] EN [8] = '{3'h0, 3'h4, 3'h0, 3'h0, 3'h3, 3'h2, 3'h1, 3'h0};
    always #2.5 core_clk = ~core_clk;
    pll_div_config u_pll_div_config (.core_clk(core_clk), .rst_b(rst_b), .reg_we(reg_we),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .vco_tick(vco_tick), .other_drivers_off(other_drivers_off), .fb_pulse(fb_pulse),
        .group_a_clk(group_a_clk), .first_output_true_leg(true_leg),
        .first_output_complement_leg(comp_leg), .hstl_en(hstl_en),
        .true_leg_en(true_leg_en), .comp_leg_en(comp_leg_en),
        .group_a_div_pd(group_a_div_pd), .vco_div_running(vco_div_running));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // strobe drops on its own edge, then an idle edge so the next write never re-raises it
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        reg_addr <= a;
        @(posedge core_clk);
        #1;
        check(reg_rdata, exp);
        @(posedge core_clk);
    endtask : rd
    task automatic commit(input logic [15:0] a, input logic [7:0] d);
        wr(a, d);
        wr(UPDATE_ADDR, 8'h01);
        repeat (4) @(posedge core_clk);
    endtask : commit
    // cycles between two rising edges of fb_pulse (sel 0) or group_a_clk (sel 1)
    task automatic period(input bit sel, input int exp);
        int n;
        int t0;
        logic p;
        logic c;
        n = 0;
        t0 = -1;
        p = 1'b1;
        while (n < 1000) begin
            @(posedge core_clk);
            #1;
            c = sel ? group_a_clk : fb_pulse;
            if (c === 1'b1 && p === 1'b0) begin
                if (t0 >= 0) break;
                t0 = n;
            end
            p = c;
            n++;
        end
        check(8'(n - t0), 8'(exp));
        @(posedge core_clk);
    endtask : period
    // ------------------------------------------------------------
    // watchdog: whole run is under two thousand cycles
    // ------------------------------------------------------------
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int k;
        logic pc;
        repeat (3) @(posedge core_clk);
        #1;
        check({5'h0, fb_pulse, group_a_div_pd, vco_div_running}, 8'h02);
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        vco_tick <= 1'b1;
        @(posedge core_clk);
        rd(FEEDBACK_DIVIDE_VALUE_ADDR, FB_RST);
        rd(VCO_DIVIDE_SELECT_ADDR, {4'h0, VCO_RST});
        rd(GROUP_A_DIVIDE_VALUE_ADDR, CH_RST);
        rd(OUTPUT_ZERO_DRIVER_CONFIG_ADDR, {2'h0, OUT_RST});
        for (int i = 0; i < 7; i++) begin
            wr(ROWS[i][31:16], ROWS[i][15:8]);
            rd(ROWS[i][31:16], ROWS[i][7:0]);
        end
        // staged vco value 5 must wait for a real update
        check({7'h0, vco_div_running}, 8'h00);
        wr(UPDATE_ADDR, 8'hFE);
        repeat (2) @(posedge core_clk);
        check({7'h0, vco_div_running}, 8'h00);
        wr(UPDATE_ADDR, 8'h01);
        repeat (2) @(posedge core_clk);
        check({7'h0, vco_div_running}, 8'h01);
        for (int v = 0; v < 16; v++) begin
            commit(VCO_DIVIDE_SELECT_ADDR, 8'h0F);
            check({7'h0, vco_div_running}, 8'h00);
            commit(VCO_DIVIDE_SELECT_ADDR, 8'(v));
            check({7'h0, vco_div_running}, {7'h0, v >= 3 && v <= 11});
        end
        commit(VCO_DIVIDE_SELECT_ADDR, 8'h07);
        // a direct change is allowed when a vco calibration follows it
        commit(VCO_DIVIDE_SELECT_ADDR, 8'h09);
        check({7'h0, vco_div_running}, 8'h01);
        // dividers: vco by 3, feedback by 20, channel by 2 + 1
        commit(VCO_DIVIDE_SELECT_ADDR, 8'h0F);
        commit(VCO_DIVIDE_SELECT_ADDR, 8'h03);
        wr(FEEDBACK_DIVIDE_VALUE_ADDR, 8'h14);
        wr(GROUP_A_DIVIDE_VALUE_ADDR, 8'h02);
        commit(OUTPUT_ZERO_DRIVER_CONFIG_ADDR, 8'h20);
        period(1'b0, 60);
        period(1'b1, 9);
        commit(GROUP_A_DIVIDE_VALUE_ADDR, 8'h00);
        period(1'b1, 3);
        for (int pol = 0; pol < 4; pol++) begin
            commit(OUTPUT_ZERO_DRIVER_CONFIG_ADDR, 8'(8'h20 | (pol << 1)));
            // settle past the edge so pc is the level the legs will follow next
            #1;
            pc = group_a_clk;
            for (int c = 0; c < 12; c++) begin
                @(posedge core_clk);
                #1;
                check({6'h0, true_leg, comp_leg},
                    {6'h0, pc ^ pol[1], pc ^ ~pol[0]});
                pc = group_a_clk;
            end
            @(posedge core_clk);
        end
        // below the minimum the feedback divider must stay silent
        commit(FEEDBACK_DIVIDE_VALUE_ADDR, 8'h13);
        k = 0;
        repeat (200) begin
            @(posedge core_clk);
            if (fb_pulse === 1'b1) k++;
        end
        check(8'(k), 8'h00);
        other_drivers_off <= 3'h7;
        for (int m = 0; m < 8; m++) begin
            commit(OUTPUT_ZERO_DRIVER_CONFIG_ADDR, 8'(m << 3));
            check({5'h0, hstl_en, true_leg_en, comp_leg_en}, {5'h0, EN[m]});
            check({7'h0, group_a_div_pd}, {7'h0, EN[m] == 3'h0});
        end
        commit(OUTPUT_ZERO_DRIVER_CONFIG_ADDR, 8'h21);
        check({4'h0, hstl_en, true_leg_en, comp_leg_en, group_a_div_pd}, 8'h01);
        other_drivers_off <= 3'h3;
        repeat (3) @(posedge core_clk);
        check({7'h0, group_a_div_pd}, 8'h00);
        conclude();
    end
endmodule : test_pll_div_config
`default_nettype wire
